// ### strap_cfg_pkg.sv
/*
  Shared constants for the start-up strap loader: timing, register map,
  reset values, lookup contents and pulse generator states.
  Assumes a single 20 MHz clock and a plain strobe register port.
*/
package strap_cfg_pkg;

  // Clock and pulse timing
  localparam int CLK_PERIOD_PS = 50000;
  localparam int PULSE_TIME_PS = 75000;
  localparam int PULSE_CYCLES = (PULSE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] PULSE_LAST = 4'(PULSE_CYCLES - 1);

  // Widths
  localparam int STRAP_W = 4;
  localparam int ROM_DEPTH = 8;
  localparam int WORD_W = 16;
  localparam int TUNE_W = 48;
  localparam int MULT_W = 8;
  localparam int ADDR_W = 4;

  // Strap field positions
  localparam int STRAP_SEL_MSB = 2;
  localparam int STRAP_CLK_BIT = 3;

  // Register word offsets
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_TUNE_LO = 4'h1;
  localparam logic [3:0] REG_TUNE_MID = 4'h2;
  localparam logic [3:0] REG_TUNE_HI = 4'h3;
  localparam logic [3:0] REG_MULT = 4'h4;

  // Reset values
  localparam logic [3:0] STRAP_RESET = 4'h0;
  localparam logic [47:0] TUNE_RESET = 48'h0;
  localparam logic [7:0] MULT_DEFAULT = 8'h28;
  localparam logic [7:0] MULT_RESET = 8'h28;

  // Start-up tuning words, W * fs / 65536 gives the output frequency
  localparam logic [15:0] ROM_INIT [ROM_DEPTH] = '{
    16'h0000, 16'h09f4, 16'h0d45, 16'h0fba,
    16'h13e8, 16'h1797, 16'h1f75, 16'h27d0
  };

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PULSE = 2'b01
  } pulse_state_t;

endpackage

// ### strap_pulse_if.sv
/*
  Carrier between the reset pulse generator and the loader core.
  Assumes both ends share the loader clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface strap_pulse_if;
  logic manual;
  logic pulse;
  logic fall;
  modport gen (input manual, output pulse, output fall);
  modport user (output manual, input pulse, input fall);
endinterface
`default_nettype wire

// ### reset_pulse_gen.sv
/*
  Internal reset pulse generator: pulse stands from reset and for a fixed
  count after it, restarted by the manual reset pin.
  Assumes the manual pin is synchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module reset_pulse_gen
  import strap_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  strap_pulse_if.gen pif
);

  pulse_state_t state;
  logic [3:0] count;

  // Pulse sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_PULSE;
      count <= 4'h0;
    end else begin
      case (state)
        ST_PULSE: begin
          if (pif.manual) begin
            count <= 4'h0;
          end else if (count == PULSE_LAST) begin
            state <= ST_IDLE;
            count <= 4'h0;
          end else begin
            count <= count + 4'h1;
          end
        end
        ST_IDLE: begin
          if (pif.manual) begin
            state <= ST_PULSE;
            count <= 4'h0;
          end
        end
        default: begin
          state <= ST_PULSE;
          count <= 4'h0;
        end
      endcase
    end
  end

  assign pif.pulse = (state == ST_PULSE);
  assign pif.fall = (state == ST_PULSE) && !pif.manual && (count == PULSE_LAST);

endmodule
`default_nettype wire

// ### tuning_rom.sv
/*
  Eight-entry table of 16-bit start-up tuning words.
  Assumes a combinational read by a three-bit strap select.
*/
`timescale 1ns/1ps
`default_nettype none
module tuning_rom
  import strap_cfg_pkg::*;
(
  input wire logic [2:0] sel,
  output logic [15:0] word
);

  logic [15:0] table_mem [ROM_DEPTH];

  // Fixed contents
  generate
    for (genvar i = 0; i < ROM_DEPTH; i++) begin : g_rom
      assign table_mem[i] = ROM_INIT[i];
    end
  endgenerate

  assign word = table_mem[sel];

endmodule
`default_nettype wire

// ### strap_startup_config_loader.sv
/*
  Start-up strap loader: internal reset pulse, release of the shared
  status pins, strap capture, start-up tuning word and clock source.
  Assumes strap resistors or an external driver set the status pins while
  the pulse stands, and a plain strobe register port with one-cycle reads.
*/
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module strap_startup_config_loader
  import strap_cfg_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic RESET_PIN,
  input wire logic [3:0] STATUS_IN,
  input wire logic [3:0] STATUS_SRC,
  output logic [3:0] STATUS_OUT,
  output logic [3:0] STATUS_OE_N,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  output logic [47:0] FREQUENCY_TUNING_WORD,
  output logic CLOCK_SOURCE_DIRECT,
  output logic [7:0] MULTIPLIER,
  output logic PULSE_ACTIVE
);

  strap_pulse_if pif ();

  logic [3:0] strap;
  logic [15:0] rom_word;
  logic [47:0] tuning_word;
  logic clock_direct;
  logic [7:0] multiplier;
  logic [15:0] next_rdata;
  logic pulse;
  logic fall;

  // Manual reset request into the pulse generator
  assign pif.manual = RESET_PIN;
  assign pulse = pif.pulse;
  assign fall = pif.fall;

  reset_pulse_gen u_pulse (
    .clk(MCLK),
    .rst(RST),
    .pif(pif)
  );

  tuning_rom u_rom (
    .sel(STATUS_IN[STRAP_SEL_MSB:0]),
    .word(rom_word)
  );

  // Register decode helper
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] offs);
    hit = (addr == offs);
  endfunction

  // Pin release follows the async reset and the pulse with no clock delay
  assign STATUS_OE_N = {STRAP_W{RST | pulse}};

  // Normal status output once the pulse is over
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      STATUS_OUT <= 4'h0;
    end else begin
      STATUS_OUT <= STATUS_SRC;
    end
  end

  // Strap capture on the falling edge of the pulse, held afterwards
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      strap <= STRAP_RESET;
    end else if (fall) begin
      strap <= STATUS_IN;
    end
  end

  // Tuning word: start-up load wins over a software write
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tuning_word <= TUNE_RESET;
    end else if (fall) begin
      tuning_word <= {rom_word, 32'h0};
    end else if (WR && hit(ADDR, REG_TUNE_LO)) begin
      tuning_word[15:0] <= WDATA;
    end else if (WR && hit(ADDR, REG_TUNE_MID)) begin
      tuning_word[31:16] <= WDATA;
    end else if (WR && hit(ADDR, REG_TUNE_HI)) begin
      tuning_word[47:32] <= WDATA;
    end
  end

  // Clock source selection
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      clock_direct <= 1'b0;
    end else if (fall) begin
      clock_direct <= STATUS_IN[STRAP_CLK_BIT];
    end
  end

  // Multiplier setting
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      multiplier <= MULT_RESET;
    end else if (fall) begin
      if (!STATUS_IN[STRAP_CLK_BIT]) begin
        multiplier <= MULT_DEFAULT;
      end
    end else if (WR && hit(ADDR, REG_MULT)) begin
      multiplier <= WDATA[7:0];
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 16'h0;
    if (hit(ADDR, REG_STATUS)) begin
      next_rdata = {10'h0, pulse, clock_direct, strap};
    end else if (hit(ADDR, REG_TUNE_LO)) begin
      next_rdata = tuning_word[15:0];
    end else if (hit(ADDR, REG_TUNE_MID)) begin
      next_rdata = tuning_word[31:16];
    end else if (hit(ADDR, REG_TUNE_HI)) begin
      next_rdata = tuning_word[47:32];
    end else if (hit(ADDR, REG_MULT)) begin
      next_rdata = {8'h0, multiplier};
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      RDATA <= 16'h0;
    end else if (RD) begin
      RDATA <= next_rdata;
    end else begin
      RDATA <= 16'h0;
    end
  end

  assign FREQUENCY_TUNING_WORD = tuning_word;
  assign CLOCK_SOURCE_DIRECT = clock_direct;
  assign MULTIPLIER = multiplier;
  assign PULSE_ACTIVE = pulse;

  // Checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  sequence s_pulse_run;
    pulse [*2] ##1 !pulse;
  endsequence

  sequence s_manual_end;
    $fell(RESET_PIN);
  endsequence

  property p_pulse_length;
    s_manual_end |-> s_pulse_run;
  endproperty

  a_pulse_length: assert property (p_pulse_length)
    else $error("Internal pulse length wrong");

  a_manual_restart: assert property (RESET_PIN |=> pulse)
    else $error("Manual reset did not start the pulse");

  a_pins_released: assert property (pulse |-> STATUS_OE_N == 4'hf)
    else $error("Status pins driven during the pulse");

  a_pins_driven: assert property (!pulse |-> STATUS_OE_N == 4'h0)
    else $error("Status pins not driven after the pulse");

  a_strap_capture: assert property (fall |=> strap == $past(STATUS_IN))
    else $error("Strap levels not captured at pulse end");

  a_strap_stable: assert property (!fall |=> $stable(strap))
    else $error("Captured straps changed outside the pulse end");

  a_rom_load: assert property (fall |=> tuning_word[47:32] == $past(rom_word))
    else $error("Start-up tuning word not loaded");

  a_rom_zero: assert property (STATUS_IN[2:0] == 3'h0 |-> rom_word == 16'h0)
    else $error("Code zero must give zero frequency");

  a_rom_top: assert property (STATUS_IN[2:0] == 3'h7 |-> rom_word == 16'h27d0)
    else $error("Top table entry wrong");

  a_clock_select: assert property (fall |=> clock_direct == $past(STATUS_IN[3]))
    else $error("Clock source not taken from top strap");

  a_mult_default: assert property (fall && !STATUS_IN[3] |=> multiplier == 8'h28)
    else $error("Multiplier not set to its start-up value");

  a_read_single: assert property (!RD |=> RDATA == 16'h0)
    else $error("Read data stood without a read strobe");

  sequence s_power_end;
    $fell(RST);
  endsequence

  sequence s_capture_edge;
    fall ##1 !pulse;
  endsequence

  property p_power_pulse;
    s_power_end |-> s_pulse_run;
  endproperty

  a_power_pulse: assert property (p_power_pulse)
    else $error("Power-up pulse length wrong");

  property p_power_capture;
    s_power_end |=> s_capture_edge;
  endproperty

  a_power_capture: assert property (p_power_capture)
    else $error("No strap capture after the power-up pulse");

  property p_manual_capture;
    s_manual_end |=> s_capture_edge;
  endproperty

  a_manual_capture: assert property (p_manual_capture)
    else $error("No strap capture after a manual reset");

  a_pins_reset: assert property (@(posedge MCLK) disable iff (1'b0)
    RST |-> STATUS_OE_N == 4'hf)
    else $error("Status pins driven during reset");

  a_rom_low: assert property (fall |=> tuning_word[31:0] == 32'h0)
    else $error("Start-up load left low tuning bits set");

  generate
    for (genvar i = 0; i < ROM_DEPTH; i++) begin : g_load_chk
      a_rom_code: assert property (@(posedge MCLK) disable iff (RST)
        fall && STATUS_IN[2:0] == 3'(i) |=> tuning_word[47:32] == ROM_INIT[i])
        else $error("Loaded word does not match its strap code");
    end
  endgenerate

  a_clock_stable: assert property (!fall |=> $stable(clock_direct))
    else $error("Clock source changed outside the pulse end");

  a_tune_hold: assert property (!fall && !WR |=> $stable(tuning_word))
    else $error("Tuning word changed without load or write");

  a_mult_hold: assert property (!fall && !WR |=> $stable(multiplier))
    else $error("Multiplier changed without load or write");

  a_mult_direct: assert property (fall && STATUS_IN[3] |=> $stable(multiplier))
    else $error("Multiplier touched in direct clock mode");

  a_status_follow: assert property (!RST |=> STATUS_OUT == $past(STATUS_SRC))
    else $error("Status output does not follow its source");

  a_write_low: assert property (WR && ADDR == REG_TUNE_LO && !fall |=>
    tuning_word[15:0] == $past(WDATA))
    else $error("Low tuning word write lost");

  a_write_mid: assert property (WR && ADDR == REG_TUNE_MID && !fall |=>
    tuning_word[31:16] == $past(WDATA))
    else $error("Middle tuning word write lost");

  a_write_high: assert property (WR && ADDR == REG_TUNE_HI && !fall |=>
    tuning_word[47:32] == $past(WDATA))
    else $error("High tuning word write lost");

  a_write_mult: assert property (WR && ADDR == REG_MULT && !fall |=>
    multiplier == $past(WDATA[7:0]))
    else $error("Multiplier write lost");

  a_read_low: assert property (RD && ADDR == REG_TUNE_LO |=>
    RDATA == $past(tuning_word[15:0]))
    else $error("Low tuning word read wrong");

  a_read_mid: assert property (RD && ADDR == REG_TUNE_MID |=>
    RDATA == $past(tuning_word[31:16]))
    else $error("Middle tuning word read wrong");

  a_read_high: assert property (RD && ADDR == REG_TUNE_HI |=>
    RDATA == $past(tuning_word[47:32]))
    else $error("High tuning word read wrong");

  a_read_status: assert property (RD && ADDR == REG_STATUS |=> RDATA[3:0] == $past(strap))
    else $error("Status read does not show the captured straps");

  a_read_mult: assert property (RD && ADDR == REG_MULT |=> RDATA == {8'h0, $past(multiplier)})
    else $error("Multiplier read wrong");

  a_read_unmapped: assert property (RD && ADDR > REG_MULT |=> RDATA == 16'h0)
    else $error("Unmapped read returned data");

endmodule
`default_nettype wire

// ### strap_partner.sv
/*
  Strap resistors on the four shared status pins.
  Assumes the loader releases a pin by raising its output enable bar.
*/
`timescale 1ns/1ps
`default_nettype none
module strap_partner (
  input wire logic [3:0] strap,
  input wire logic [3:0] oe_n,
  input wire logic [3:0] drive,
  output logic [3:0] pin
);
  // Released pin settles to its pull level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin[i] = oe_n[i] ? strap[i] : drive[i];
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
/*
  Self-checking bench for the start-up strap loader.
  Assumes the strap partner model and a 20 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import strap_cfg_pkg::*;
  logic mclk = 0, rst = 1, reset_pin = 0, wr = 0, rd = 0, clk_direct, pulse;
  logic [3:0] status_in, status_out, oe_n, strap = 4'h3, status_src = 4'h0, addr = 4'h0;
  logic [15:0] wdata = 16'h0, rdata, rv;
  logic [47:0] tune_word;
  logic [7:0] mult;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int freq_e5 [8] = '{0, 3887939, 5183411, 6143188, 7775879, 9214783, 12287903, 15551758};

  strap_startup_config_loader dut_u (.MCLK(mclk), .RST(rst), .RESET_PIN(reset_pin),
    .STATUS_IN(status_in), .STATUS_SRC(status_src), .STATUS_OUT(status_out),
    .STATUS_OE_N(oe_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .FREQUENCY_TUNING_WORD(tune_word), .CLOCK_SOURCE_DIRECT(clk_direct), .MULTIPLIER(mult),
    .PULSE_ACTIVE(pulse));
  strap_partner strap_u (.strap(strap), .oe_n(oe_n), .drive(status_out), .pin(status_in));

  initial begin
    forever #25 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("[ERR] run length expected under 5000 seen 5000");
      give_verdict();
    end
  end

  task automatic check(input string name, input logic [47:0] exp, input logic [47:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_pulse_end(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (pulse === 1'b1 && n < 20);
  endtask

  task automatic expect_load(input logic [3:0] s, input logic [7:0] m);
    real f;
    f = tune_word[47:32] * 1000.0 / 65536.0 * 1.0e5 + 0.5;
    check("tuning word low", 48'h0, {16'h0, tune_word[31:0]});
    check("start frequency", 48'(freq_e5[s[2:0]]), 48'($rtoi(f)));
    check("clock source", 48'(s[3]), 48'(clk_direct));
    check("multiplier", 48'(m), 48'(mult));
    check("pins driven", 48'h0, 48'(oe_n));
  endtask

  task automatic power_up(input logic [3:0] s);
    int n;
    @(posedge mclk);
    strap <= s;
    rst <= 1'b1;
    #0.9 check("pins released", 48'hf, 48'(oe_n));
    check("pulse in reset", 48'h1, 48'(pulse));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    wait_pulse_end(n);
    check("pulse length", 48'(PULSE_CYCLES), 48'(n));
    expect_load(s, MULT_DEFAULT);
  endtask

  task automatic manual_capture(input logic [3:0] s);
    int n;
    bus_write(REG_MULT, 16'h0011);
    @(posedge mclk);
    strap <= s;
    reset_pin <= 1'b1;
    @(posedge mclk);
    reset_pin <= 1'b0;
    #1 check("pins released", 48'hf, 48'(oe_n));
    check("manual pulse", 48'h1, 48'(pulse));
    wait_pulse_end(n);
    check("manual pulse length", 48'(PULSE_CYCLES), 48'(n));
    expect_load(s, s[3] ? 8'h11 : MULT_DEFAULT);
  endtask

  task automatic tune_regs();
    bus_write(REG_TUNE_LO, 16'h1234);
    bus_write(REG_TUNE_MID, 16'h5678);
    bus_write(REG_TUNE_HI, 16'h9abc);
    bus_write(REG_MULT, 16'h0033);
    bus_read(REG_TUNE_LO, rv);
    check("tuning word low read", 48'h1234, 48'(rv));
    bus_read(REG_TUNE_MID, rv);
    check("tuning word mid read", 48'h5678, 48'(rv));
    bus_read(REG_TUNE_HI, rv);
    check("tuning word high read", 48'h9abc, 48'(rv));
    bus_read(REG_MULT, rv);
    check("multiplier read", 48'h0033, 48'(rv));
    check("tuning word", 48'h9abc56781234, tune_word);
    check("clock source kept", 48'h0, 48'(clk_direct));
  endtask

  task automatic hold_after(input logic [3:0] s, input logic [7:0] m);
    @(posedge mclk);
    strap <= ~s;
    status_src <= 4'h6;
    repeat (3) @(posedge mclk);
    #1 check("status output", 48'h6, 48'(status_out));
    bus_read(REG_STATUS, rv);
    check("status register", {43'h0, s[3], s}, 48'(rv));
    bus_read(4'hf, rv);
    check("unmapped read", 48'h0, 48'(rv));
    expect_load(s, m);
  endtask

  initial begin
    power_up(4'h3);
    hold_after(4'h3, MULT_DEFAULT);
    tune_regs();
    for (int c = 0; c < 16; c++) begin
      manual_capture(4'(c));
    end
    power_up(4'hd);
    hold_after(4'hd, MULT_DEFAULT);
    give_verdict();
  end
endmodule
`default_nettype wire
